//--- verilog/cpu_fpu_timing_map.svh
// Timing constants for the processor and coprocessor cycle-time sequencer
`ifndef CPU_FPU_TIMING_MAP_SVH
`define CPU_FPU_TIMING_MAP_SVH

`define CLK_NS            10
`define TICK_NS           150
`define TICK_CYC          (`TICK_NS / `CLK_NS)

// Floating-point handshake phases, ns
`define FP_PREINT_NS      450
`define FP_RESYNC_NS      450
`define FP_INIT_NS        300
`define FP_DISENG_NS      300
`define FP_XFER_LOAD_NS   300
`define FP_XFER_STORE_NS  1200

// Operand address calculation per mode, ns
`define ADDR_M0_NS        0
`define ADDR_M1_NS        300
`define ADDR_M2_NS        300
`define ADDR_M3_NS        600
`define ADDR_M4_NS        300
`define ADDR_M5_NS        750
`define ADDR_M6_NS        600
`define ADDR_M7_NS        1050

// Memory cycles, ns
`define MEM_READ_HIT_NS   300
`define MEM_READ_MISS_NS  1320
`define MEM_WRITE_NS      750

// Ordinary instruction times, ns
`define BRANCH_TAKEN_NS   600
`define BRANCH_NOT_NS     300
`define LOOP_TAKEN_NS     600
`define LOOP_FALL_NS      750
`define SHIFT_REG_NS      750
`define SHIFT_MEM_NS      900
`define SHIFT_STEP_NS     150
`define ROTR_MEM_NS       1200
`define ODD_BYTE_NS       150
`define PC_DST_NS         300
`define SINGLE_REG_NS     300
`define SINGLE_MEM_NS     1200
`define SUB_RET_NS        1050
`define INT_RET_NS        1500
`define TRAP_NS           3300
`define INT_SERV_NS       2310
`define WAIT_NS           450
`define WAIT_POLL_NS      300
`define HALT_NS           1050

`endif

//--- verilog/cpu_fpu_timing_pkg.sv
// Types for the processor and coprocessor cycle-time sequencer
package cpu_fpu_timing_pkg;

   typedef enum logic [3:0] {
      OP_SINGLE      = 4'h0,
      OP_ROTATE_R    = 4'h1,
      OP_MULTI_SHIFT = 4'h2,
      OP_BRANCH      = 4'h3,
      OP_LOOP        = 4'h4,
      OP_SUB_RETURN  = 4'h5,
      OP_INT_RETURN  = 4'h6,
      OP_TRAP        = 4'h7,
      OP_INT_SERVICE = 4'h8,
      OP_WAIT        = 4'h9,
      OP_HALT        = 4'ha,
      OP_MEM_READ    = 4'hb,
      OP_MEM_WRITE   = 4'hc,
      OP_FP          = 4'hd
   } op_kind_t;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_RUN       = 4'h1,
      ST_WAIT_POLL = 4'h2,
      ST_FP_PRE    = 4'h3,
      ST_FP_ADDR   = 4'h4,
      ST_FP_WAIT   = 4'h5,
      ST_FP_RESYNC = 4'h6,
      ST_FP_INIT   = 4'h7,
      ST_FP_XFER   = 4'h8,
      ST_FP_DISENG = 4'h9
   } seq_state_t;

   typedef struct packed {
      seq_state_t  st;
      logic [15:0] timer;
      logic [15:0] elapsed;
      logic [15:0] elapsed_out;
      logic [7:0]  fp_rem;
      logic [9:0]  wait_ticks;
      logic [3:0]  div;
      logic [1:0]  bus_sync;
      logic        fp_store;
      logic [2:0]  fp_words;
      logic [7:0]  fp_exec;
      logic [2:0]  fp_mode;
      logic        done;
      logic        fpu_start;
   } seq_regs_t;

endpackage

//--- verilog/cpu_fpu_timing.sv
// Cycle-time sequencer for ordinary and floating-point instruction execution
//////////////////////////////////////////////////////////////////////////////
`include "cpu_fpu_timing_map.svh"

// Functional notes
// RL1: Floating-point decode and register copy phase always lasts 450 ns.
// RL2: Operand transfer costs 300 ns per loaded word, 1200 ns per stored word.
// RL3: Disengage and next-instruction fetch after hand-off takes 300 ns.
// RL4: Add 450 ns resync only when the processor really stalled.
// RL5: Total time sums decode, address, wait, resync, initiation, transfer, disengage.
// RL6: Load stall is coprocessor time left after interposed work; never negative.
// RL7: Store stall is clamped leftover plus store execution minus address, clamped.
// RL8: Address calculation 0/300/300/600/300/750/600/1050 ns for modes 0 to 7.
// RL9: Coprocessor completes load in 360 ns; adds take 900 to 4140 ns.
// RL10: Cache read hit 0.30 us, read miss 1.32 us, write 0.75 us.
// RL11: Branch 0.60/0.30 us; loop decrement 0.60 branching, 0.75 falling through.
// RL12: Multi-shift 0.75 us register, 0.90 us memory, plus 0.15 us per bit.
// RL13: Rotate/shift right on memory 1.20 us, plus 0.15 us for odd byte.
// RL14: Single-operand with program counter destination adds 0.30 us.
// RL15: Simple single-operand ops take 0.30 us register, 1.20 us memory.
// RL16: Return 1.05, interrupt return 1.50, trap 3.30, interrupt service 2.31 us.
// RL17: Wait takes 0.45 us, then polls bus requests every 0.3 us; halt 1.05 us.
// RL18: Coprocessor runs on independently while ordinary instructions proceed.
// RL19: Load-class ops overlap; store-class ops finish in the coprocessor first.
// RL20: Phase durations are counted in whole 150 ns processor ticks.
module cpu_fpu_timing
   import cpu_fpu_timing_pkg::*;
#(
   parameter int CNT_W = 16
)(
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   input  wire logic       i_op_valid,
   output logic            o_op_ready,
   input  wire op_kind_t   i_op_kind,
   input  wire logic [2:0] i_mode,
   input  wire logic       i_odd_byte,
   input  wire logic       i_dst_pc,
   input  wire logic       i_taken,
   input  wire logic       i_cache_hit,
   input  wire logic [5:0] i_shift_count,
   input  wire logic       i_fp_store,
   input  wire logic [2:0] i_fp_words,
   input  wire logic [7:0] i_fp_exec_ticks,
   input  wire logic       i_bus_request,
   output logic            o_done,
   output logic [15:0]     o_elapsed_cyc,
   output seq_state_t      o_phase,
   output logic            o_stall,
   output logic            o_fpu_start,
   output logic            o_fpu_busy
);

   // Elapsed runs from the accepting edge to the edge that raises done,
   // so an op of D cycles reports exactly D; the floating wait check adds one
   localparam logic [15:0] TICK_CYC = 16'(`TICK_CYC);

   seq_regs_t r_q;
   seq_regs_t r_d;

   //////////////////////////////////////////////////////////////////////////////
   // Time conversions
   // Every listed time is a whole number of clock cycles and every address time a whole number of ticks, so the divisions are exact

   function automatic logic [15:0] ns_cyc(input int ns);
      ns_cyc = 16'(ns / `CLK_NS);
   endfunction

   function automatic logic [15:0] ticks_cyc(input logic [15:0] t);
      ticks_cyc = 16'(t * TICK_CYC); // RL20
   endfunction

   function automatic logic [9:0] addr_ticks(input logic [2:0] m);
      int ns;
      unique case (m) // RL8
         3'h0: ns = `ADDR_M0_NS;
         3'h1: ns = `ADDR_M1_NS;
         3'h2: ns = `ADDR_M2_NS;
         3'h3: ns = `ADDR_M3_NS;
         3'h4: ns = `ADDR_M4_NS;
         3'h5: ns = `ADDR_M5_NS;
         3'h6: ns = `ADDR_M6_NS;
         3'h7: ns = `ADDR_M7_NS;
      endcase
      addr_ticks = 10'(ns / `TICK_NS); // RL20
   endfunction

   // Duration of an ordinary instruction or memory cycle, in clock cycles
   // Register mode is mode 0; the program counter extra applies only there
   function automatic logic [15:0] op_cyc(input op_kind_t k, input logic [2:0] m, input logic odd,
                                          input logic pc, input logic tk, input logic hit,
                                          input logic [5:0] sh);
      logic [15:0] c;
      logic        reg_mode;
      reg_mode = (m == 3'h0);
      c = 16'h0000;
      unique case (k)
         OP_SINGLE:
         begin
            c = reg_mode ? ns_cyc(`SINGLE_REG_NS) : ns_cyc(`SINGLE_MEM_NS); // RL15
            if (reg_mode && pc)
               c = c + ns_cyc(`PC_DST_NS); // RL14
         end
         OP_ROTATE_R:
         begin
            if (reg_mode)
            begin
               c = ns_cyc(`SINGLE_REG_NS);
               if (pc)
                  c = c + ns_cyc(`PC_DST_NS); // RL14
            end
            else
            begin
               c = ns_cyc(`ROTR_MEM_NS); // RL13
               if (odd)
                  c = c + ns_cyc(`ODD_BYTE_NS); // RL13
            end
         end
         OP_MULTI_SHIFT:
            c = (reg_mode ? ns_cyc(`SHIFT_REG_NS) : ns_cyc(`SHIFT_MEM_NS))
                + 16'(sh * ns_cyc(`SHIFT_STEP_NS)); // RL12
         OP_BRANCH:      c = tk ? ns_cyc(`BRANCH_TAKEN_NS) : ns_cyc(`BRANCH_NOT_NS); // RL11
         OP_LOOP:        c = tk ? ns_cyc(`LOOP_TAKEN_NS) : ns_cyc(`LOOP_FALL_NS); // RL11
         OP_SUB_RETURN:  c = ns_cyc(`SUB_RET_NS); // RL16
         OP_INT_RETURN:  c = ns_cyc(`INT_RET_NS); // RL16
         OP_TRAP:        c = ns_cyc(`TRAP_NS); // RL16
         OP_INT_SERVICE: c = ns_cyc(`INT_SERV_NS); // RL16
         OP_WAIT:        c = ns_cyc(`WAIT_NS); // RL17
         OP_HALT:        c = ns_cyc(`HALT_NS); // RL17
         OP_MEM_READ:    c = hit ? ns_cyc(`MEM_READ_HIT_NS) : ns_cyc(`MEM_READ_MISS_NS); // RL10
         OP_MEM_WRITE:   c = ns_cyc(`MEM_WRITE_NS); // RL10
         default:        c = 16'h0001;
      endcase
      op_cyc = c;
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // Next state
   // One shared countdown times every phase but the floating wait; a phase ends when it reaches one,
   // so the next phase is loaded on the same edge without a dead cycle

   // Decoded once per cycle from the registered state
   logic        tick;
   logic        phase_end;
   logic [10:0] store_wait;
   logic [15:0] xfer_cyc;
   logic        bus_req_s;

   always_comb
   begin
      r_d = r_q;
      r_d.done = 1'b0;
      r_d.fpu_start = 1'b0;
      tick = (r_q.div == 4'(`TICK_CYC - 1));
      phase_end = (r_q.timer <= 16'h0001);
      bus_req_s = r_q.bus_sync[1];
      // Store stall is fixed once, at the end of decode, from what the coprocessor
      // still owes plus its own store time; it cannot grow afterwards
      store_wait = 11'(r_q.fp_rem) + 11'(r_q.fp_exec) - 11'(addr_ticks(r_q.fp_mode)); // RL7
      if (11'(r_q.fp_rem) + 11'(r_q.fp_exec) <= 11'(addr_ticks(r_q.fp_mode)))
         store_wait = 11'h000; // RL7
      xfer_cyc = r_q.fp_store ? 16'(r_q.fp_words * ns_cyc(`FP_XFER_STORE_NS))
                              : 16'(r_q.fp_words * ns_cyc(`FP_XFER_LOAD_NS)); // RL2

      // Bus request is a pin: two flops before the poll reads it
      r_d.bus_sync = {r_q.bus_sync[0], i_bus_request};
      r_d.div = tick ? 4'h0 : r_q.div + 4'h1; // RL20
      // Coprocessor keeps counting whatever the processor does
      if (tick && r_q.fp_rem != 8'h00)
         r_d.fp_rem = r_q.fp_rem - 8'h01; // RL18
      if (r_q.timer != 16'h0000)
         r_d.timer = r_q.timer - 16'h0001;
      if (r_q.st != ST_IDLE)
         r_d.elapsed = r_q.elapsed + 16'h0001; // RL5

      unique case (r_q.st)
         ST_IDLE:
         begin
            r_d.elapsed = 16'h0000;
            // Coprocessor fields are latched on acceptance and held for the
            // whole op, since the requester may change them afterwards
            if (i_op_valid)
            begin
               r_d.fp_store = i_fp_store;
               r_d.fp_words = i_fp_words;
               r_d.fp_exec = i_fp_exec_ticks;
               r_d.fp_mode = i_mode;
               if (i_op_kind == OP_FP)
               begin
                  r_d.st = ST_FP_PRE;
                  r_d.timer = ns_cyc(`FP_PREINT_NS); // RL1
               end
               else
               begin
                  r_d.st = ST_RUN;
                  r_d.timer = op_cyc(i_op_kind, i_mode, i_odd_byte, i_dst_pc, i_taken, i_cache_hit,
                                     i_shift_count);
               end
               if (i_op_kind == OP_WAIT)
                  r_d.st = ST_WAIT_POLL;
            end
         end
         // Ordinary ops only count their timer down
         ST_RUN:
            if (phase_end)
            begin
               r_d.st = ST_IDLE;
               r_d.done = 1'b1;
               r_d.elapsed_out = r_q.elapsed + 16'h0001;
            end
         // Polling keeps its rhythm until a synchronised bus request is seen
         ST_WAIT_POLL:
            if (phase_end)
            begin
               if (bus_req_s)
               begin
                  r_d.st = ST_IDLE;
                  r_d.done = 1'b1;
                  r_d.elapsed_out = r_q.elapsed + 16'h0001;
               end
               else
                  r_d.timer = ns_cyc(`WAIT_POLL_NS); // RL17
            end
         // Zero-length address phase is skipped; the wait check still costs a cycle
         ST_FP_PRE:
            if (phase_end)
            begin
               r_d.wait_ticks = 10'(store_wait);
               if (addr_ticks(r_q.fp_mode) != 10'h000)
               begin
                  r_d.st = ST_FP_ADDR;
                  r_d.timer = ticks_cyc(16'(addr_ticks(r_q.fp_mode))); // RL8
               end
               else
                  r_d.st = ST_FP_WAIT;
            end
         ST_FP_ADDR:
            if (phase_end)
               r_d.st = ST_FP_WAIT;
         ST_FP_WAIT:
         begin
            // Wait resolves on tick boundaries, so a stall may end up to one tick early;
            // resync is entered only from here, never on an unstalled op
            // Store class: stall ends when the computed wait has run out
            if (r_q.fp_store)
            begin
               if (r_q.wait_ticks == 10'h000)
               begin
                  r_d.st = ST_FP_INIT;
                  r_d.timer = ns_cyc(`FP_INIT_NS);
               end
               else if (tick)
                  r_d.wait_ticks = r_q.wait_ticks - 10'h001; // RL7 RL19
               if (r_q.wait_ticks == 10'h001 && tick)
               begin
                  r_d.st = ST_FP_RESYNC;
                  r_d.timer = ns_cyc(`FP_RESYNC_NS); // RL4
               end
            end
            // Load class: stall until the previous coprocessor op is done
            else if (r_q.fp_rem == 8'h00)
            begin
               r_d.st = ST_FP_INIT; // RL6 RL4
               r_d.timer = ns_cyc(`FP_INIT_NS);
            end
            else if (r_q.fp_rem == 8'h01 && tick)
            begin
               r_d.st = ST_FP_RESYNC; // RL6
               r_d.timer = ns_cyc(`FP_RESYNC_NS); // RL4
            end
         end
         ST_FP_RESYNC:
            if (phase_end)
            begin
               r_d.st = ST_FP_INIT;
               r_d.timer = ns_cyc(`FP_INIT_NS);
            end
         ST_FP_INIT:
            if (phase_end)
            begin
               // Coprocessor is started on the last initiation edge
               r_d.fpu_start = 1'b1;
               if (xfer_cyc != 16'h0000)
               begin
                  r_d.st = ST_FP_XFER;
                  r_d.timer = xfer_cyc; // RL2
               end
               else
               begin
                  r_d.st = ST_FP_DISENG;
                  r_d.timer = ns_cyc(`FP_DISENG_NS); // RL3
                  if (!r_q.fp_store)
                     r_d.fp_rem = r_q.fp_exec; // RL19
               end
            end
         ST_FP_XFER:
            if (phase_end)
            begin
               r_d.st = ST_FP_DISENG;
               r_d.timer = ns_cyc(`FP_DISENG_NS); // RL3
               // Load class runs on once all operands are held
               if (!r_q.fp_store)
                  r_d.fp_rem = r_q.fp_exec; // RL19 RL9
            end
         // Done and the elapsed total rise together on the last disengage edge
         ST_FP_DISENG:
            if (phase_end)
            begin
               r_d.st = ST_IDLE;
               r_d.done = 1'b1;
               r_d.elapsed_out = r_q.elapsed + 16'h0001; // RL5
            end
         default:
            r_d.st = ST_IDLE;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////////
   // State register
   // Synchronous reset; the tick divider restarts at zero with everything else

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         r_q <= '0;
         r_q.st <= ST_IDLE;
      end
      else
         r_q <= r_d;
   end

   // Ready and stall decode the state, busy the coprocessor count; done and data outputs come straight from flops
   assign o_op_ready    = (r_q.st == ST_IDLE);
   assign o_done        = r_q.done;
   assign o_elapsed_cyc = r_q.elapsed_out;
   assign o_phase       = r_q.st;
   assign o_stall       = (r_q.st == ST_FP_WAIT);
   assign o_fpu_start   = r_q.fpu_start;
   assign o_fpu_busy    = (r_q.fp_rem != 8'h00);

endmodule

//--- sim/cpu_fpu_timing_monitor.sv
// Concurrent checks on the sequencer ports, bound to the top module
//////////////////////////////////////////////////////////////////////
module cpu_fpu_timing_monitor
   import cpu_fpu_timing_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   input  wire logic        i_op_valid,
   input  wire logic        o_op_ready,
   input  wire op_kind_t    i_op_kind,
   input  wire logic        i_taken,
   input  wire logic        o_done,
   input  wire logic [15:0] o_elapsed_cyc,
   input  wire seq_state_t  o_phase,
   input  wire logic        o_stall
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   // Phase seen one cycle ago and how many cycles it had lasted then
   seq_state_t  last_q;
   logic [15:0] run_q;
   always_ff @(posedge i_clk_sys)
   begin
      last_q <= i_rst ? ST_IDLE : o_phase;
      run_q  <= (i_rst || o_phase != last_q) ? 16'h0 : run_q + 16'h1;
   end

   property p_pre_len;
      last_q == ST_FP_PRE && o_phase != ST_FP_PRE |-> run_q == 16'd44;
   endproperty
   a_pre_len: assert property (p_pre_len) else $error("decode phase length wrong");
   property p_init_len;
      last_q == ST_FP_INIT && o_phase != ST_FP_INIT |-> run_q == 16'd29;
   endproperty
   a_init_len: assert property (p_init_len) else $error("initiation phase length wrong");
   property p_diseng_len;
      last_q == ST_FP_DISENG && o_phase != ST_FP_DISENG |-> run_q == 16'd29 ##[0:1] o_done;
   endproperty
   a_diseng_len: assert property (p_diseng_len) else $error("disengage phase wrong");
   property p_resync_len;
      last_q == ST_FP_RESYNC && o_phase != ST_FP_RESYNC |-> run_q == 16'd44;
   endproperty
   a_resync_len: assert property (p_resync_len) else $error("resync phase length wrong");
   property p_resync_cause;
      o_phase == ST_FP_RESYNC && last_q != ST_FP_RESYNC |-> last_q == ST_FP_WAIT;
   endproperty
   a_resync_cause: assert property (p_resync_cause) else $error("resync without wait");
   property p_stall_flag;
      o_stall == (o_phase == ST_FP_WAIT);
   endproperty
   a_stall_flag: assert property (p_stall_flag) else $error("stall flag off phase");
   property p_branch_taken;
      i_op_valid && o_op_ready && i_op_kind == OP_BRANCH && i_taken |->
         ##[60:62] (o_done && o_elapsed_cyc == 16'd60);
   endproperty
   a_branch_taken: assert property (p_branch_taken) else $error("taken branch time wrong");
   property p_branch_not;
      i_op_valid && o_op_ready && i_op_kind == OP_BRANCH && !i_taken |->
         ##[30:32] (o_done && o_elapsed_cyc == 16'd30);
   endproperty
   a_branch_not: assert property (p_branch_not) else $error("untaken branch time wrong");
   property p_elapsed_hold;
      !o_done && !$past(i_rst) |-> $stable(o_elapsed_cyc);
   endproperty
   a_elapsed_hold: assert property (p_elapsed_hold) else $error("elapsed changed without done");
   property p_take;
      i_op_valid && o_op_ready |=> !o_op_ready && o_phase != ST_IDLE && !o_done;
   endproperty
   a_take: assert property (p_take) else $error("request not taken");
endmodule

bind cpu_fpu_timing cpu_fpu_timing_monitor i_cpu_fpu_timing_monitor (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
   .i_op_valid(i_op_valid), .o_op_ready(o_op_ready), .i_op_kind(i_op_kind), .i_taken(i_taken),
   .o_done(o_done), .o_elapsed_cyc(o_elapsed_cyc), .o_phase(o_phase), .o_stall(o_stall));

//--- sim/fpu_coproc_model.sv
// Behavioural model of the attached floating-point coprocessor
module fpu_coproc_model (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   input  wire logic       i_start,
   input  wire logic [7:0] i_exec_ticks,
   input  wire logic       i_store,
   input  wire logic [2:0] i_words,
   output logic [15:0]     o_rem
);
   timeunit 1ns;
   timeprecision 1ps;
   // Counts down on its own once started, whatever the processor does
   always @(posedge i_clk_sys)
      if (i_rst)
         o_rem <= 16'h0;
      else if (i_start)
         o_rem <= i_store ? 16'h0 : 16'(i_words) * 16'd30 + 16'(i_exec_ticks) * 16'd15;
      else if (o_rem != 16'h0)
         o_rem <= o_rem - 16'h1;
endmodule

//--- sim/cpu_fpu_timing_tb.sv
// Self-checking bench for the cycle-time sequencer
//////////////////////////////////////////////////////////////////////
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %s exp %0d got %0d", n, e, g); end end
module cpu_fpu_timing_tb
   import cpu_fpu_timing_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys, i_rst, i_op_valid, i_odd_byte, i_dst_pc, i_taken, i_cache_hit, i_fp_store, i_bus_request;
   logic o_op_ready, o_done, o_stall, o_fpu_start, o_fpu_busy, resync_seen;
   op_kind_t    i_op_kind;
   logic [2:0]  i_mode, i_fp_words;
   logic [5:0]  i_shift_count;
   logic [7:0]  i_fp_exec_ticks;
   logic [15:0] o_elapsed_cyc, fp_rem;
   logic [31:0] seed = 32'h17205a94;
   seq_state_t  o_phase;
   int          err_total = 0;
   int          total_checks = 0;

   cpu_fpu_timing i_cpu_fpu_timing (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_op_valid(i_op_valid),
      .o_op_ready(o_op_ready), .i_op_kind(i_op_kind), .i_mode(i_mode), .i_odd_byte(i_odd_byte),
      .i_dst_pc(i_dst_pc), .i_taken(i_taken), .i_cache_hit(i_cache_hit), .i_shift_count(i_shift_count),
      .i_fp_store(i_fp_store), .i_fp_words(i_fp_words), .i_fp_exec_ticks(i_fp_exec_ticks),
      .i_bus_request(i_bus_request), .o_done(o_done), .o_elapsed_cyc(o_elapsed_cyc), .o_phase(o_phase),
      .o_stall(o_stall), .o_fpu_start(o_fpu_start), .o_fpu_busy(o_fpu_busy));
   fpu_coproc_model i_fpu_coproc_model (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_start(o_fpu_start),
      .i_exec_ticks(i_fp_exec_ticks), .i_store(i_fp_store), .i_words(i_fp_words), .o_rem(fp_rem));

   initial
   begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys)
      if (o_phase == ST_FP_RESYNC)
         resync_seen <= 1'b1;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic int addr_cyc(input logic [2:0] m);
      int t[8] = '{0, 30, 30, 60, 30, 75, 60, 105};
      return t[m];
   endfunction
   function automatic int fp_base();
      return 45 + addr_cyc(i_mode) + 1 + 30 + i_fp_words * (i_fp_store ? 120 : 30) + 30;
   endfunction
   function automatic int ord_cyc();
      case (i_op_kind)
         OP_SINGLE:      return (i_mode == 3'h0) ? 30 + (i_dst_pc ? 30 : 0) : 120;
         OP_ROTATE_R:    return (i_mode == 3'h0) ? 30 : 120 + (i_odd_byte ? 15 : 0);
         OP_MULTI_SHIFT: return ((i_mode == 3'h0) ? 75 : 90) + 15 * i_shift_count;
         OP_BRANCH:      return i_taken ? 60 : 30;
         OP_LOOP:        return i_taken ? 60 : 75;
         OP_SUB_RETURN:  return 105;
         OP_INT_RETURN:  return 150;
         OP_TRAP:        return 330;
         OP_INT_SERVICE: return 231;
         OP_MEM_READ:    return i_cache_hit ? 30 : 132;
         OP_MEM_WRITE:   return 75;
         default:        return 105;
      endcase
   endfunction

   task automatic end_sim();
      if (err_total == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bound(input int n, input int lim);
      if (n >= lim)
      begin
         err_total++;
         end_sim();
      end
   endtask
   // Called at a falling edge; returns just after the edge that shows done
   task automatic issue(input int lo, input int hi);
      int n;
      i_op_valid = 1'b1;
      @(negedge i_clk_sys);
      i_op_valid = 1'b0;
      resync_seen = 1'b0;
      for (n = 0; o_done !== 1'b1 && n < 4000; n++)
      begin
         @(posedge i_clk_sys);
         #1;
      end
      bound(n, 4000);
      if (lo == hi)
         `CHK("elapsed", lo, o_elapsed_cyc)
      else
         `CHK("elapsed_in_range", 1'b1, o_elapsed_cyc >= lo && o_elapsed_cyc <= hi)
   endtask
   task automatic idle_fp();
      int n;
      for (n = 0; fp_rem != 16'h0 && n < 5000; n++)
         @(negedge i_clk_sys);
      bound(n, 5000);
      repeat (20) @(negedge i_clk_sys);
      `CHK("fpu_idle", 1'b0, o_fpu_busy)
   endtask

   initial
   begin
      int w;
      {i_rst, i_op_valid, i_odd_byte, i_dst_pc, i_taken, i_cache_hit, i_fp_store, i_bus_request} = 8'h80;
      {i_mode, i_fp_words, i_shift_count, resync_seen} = 13'h0;
      i_op_kind = OP_SINGLE;
      i_fp_exec_ticks = 8'h3;
      repeat (8) @(negedge i_clk_sys);
      i_rst = 1'b0;
      // Every ordinary kind but wait once, then random kinds and fields
      for (int k = 0; k < 60; k++)
      begin
         @(negedge i_clk_sys);
         seed = lfsr(seed);
         i_op_kind = op_kind_t'(4'((k < 13) ? k : seed[7:0] % 13));
         if (i_op_kind == OP_WAIT)
            i_op_kind = OP_HALT;
         i_mode = seed[10:8];
         i_odd_byte = seed[11] && i_op_kind == OP_ROTATE_R && i_mode != 3'h0;
         i_dst_pc = seed[12] && i_op_kind == OP_SINGLE && i_mode == 3'h0;
         {i_taken, i_cache_hit} = seed[14:13];
         i_shift_count = (k == 2) ? 6'h3f : seed[20:15];
         issue(ord_cyc(), ord_cyc());
      end
      @(negedge i_clk_sys);
      i_op_kind = OP_WAIT;
      i_bus_request = 1'b1;
      issue(45, 45);
      @(negedge i_clk_sys);
      i_bus_request = 1'b0;
      fork
         issue(100, 140);
         begin
            repeat (100) @(negedge i_clk_sys);
            i_bus_request = 1'b1;
         end
      join
      // Idle coprocessor, every mode, both classes
      for (int m = 0; m < 16; m++)
      begin
         idle_fp();
         seed = lfsr(seed);
         i_op_kind = OP_FP;
         i_mode = 3'(m);
         i_fp_store = m[3];
         i_fp_words = seed[0] ? 3'h4 : 3'h2;
         i_fp_exec_ticks = m[3] ? 8'(2 + seed[12:8] % 26) : 8'h3;
         w = i_fp_store ? i_fp_exec_ticks * 15 - addr_cyc(i_mode) : 0;
         if (w <= 0)
            issue(fp_base(), fp_base());
         else
            issue(fp_base() + w + 30, fp_base() + w + 44);
         `CHK("resync", w > 0, resync_seen)
      end
      // Long add followed at once by a load must stall
      idle_fp();
      {i_mode, i_fp_store, i_fp_words, i_fp_exec_ticks} = {3'h0, 1'b0, 3'h2, 8'd27};
      issue(fp_base(), fp_base());
      `CHK("busy", 1'b1, o_fpu_busy)
      @(negedge i_clk_sys);
      i_fp_exec_ticks = 8'h3;
      issue(fp_base() + 45, fp_base() + 400);
      `CHK("resync", 1'b1, resync_seen)
      // Short add hidden behind an interposed trap: no stall
      idle_fp();
      i_fp_exec_ticks = 8'h6;
      issue(fp_base(), fp_base());
      @(negedge i_clk_sys);
      i_op_kind = OP_TRAP;
      issue(330, 330);
      @(negedge i_clk_sys);
      i_op_kind = OP_FP;
      issue(fp_base(), fp_base());
      `CHK("resync", 1'b0, resync_seen)
      // Reset in mid-operation
      @(negedge i_clk_sys);
      i_op_kind = OP_TRAP;
      i_op_valid = 1'b1;
      @(negedge i_clk_sys);
      i_op_valid = 1'b0;
      repeat (5) @(negedge i_clk_sys);
      i_rst = 1'b1;
      @(negedge i_clk_sys);
      i_rst = 1'b0;
      `CHK("phase", ST_IDLE, o_phase)
      `CHK("ready", 1'b1, o_op_ready)
      {i_op_kind, i_taken} = {OP_BRANCH, 1'b1};
      issue(60, 60);
      end_sim();
   end
endmodule
